//--- inc/kbcof_pkg.sv
// Constants and types for the keyboard-controller output flag block
// Summary of operation
// - EC writes at 0h or Ch set the output-buffer-full status bit 0.
// - EC data writes can set the keyboard flag, aux writes the mouse flag.
// - The keyboard output flag is zero after power-up.
// - A host read of the shared data port clears the keyboard output flag.
// - Under override the keyboard flag is a firmware latch set and cleared.
// - The keyboard-flag register reads the present keyboard flag in bit 0.
// - Keyboard irq source is low with irq enable 0, else the keyboard flag.
// - Mouse irq source is low with irq enable 0, else the mouse flag.
// - The mouse output flag is zero after the standby system reset.
// - A host read of the data port clears the mouse output flag.
// - Firmware writes 1 or 0 to the mouse status field to set or clear it.
// - Mouse hold 0 follows aux data writes, hold 1 the status latch.
// - The input-buffer-full event pulses when the input-full flag rises.
// - The output-buffer-empty event pulses when a host read clears full.
// - The reset pulse counter runs from a 1 MHz clock.
`default_nettype none
package kbcof_pkg;
  localparam int          EC_AW          = 5;
  localparam int          DW             = 8;
  // EC register offsets
  localparam logic [4:0]  OFS_DATA       = 5'h00;
  localparam logic [4:0]  OFS_STATUS     = 5'h04;
  localparam logic [4:0]  OFS_CTRL       = 5'h08;
  localparam logic [4:0]  OFS_AUX        = 5'h0C;
  localparam logic [4:0]  OFS_KBFLAG     = 5'h10;
  localparam logic [4:0]  OFS_RSTCTL     = 5'h14;
  // Status fields
  localparam int          ST_OBF         = 0;
  localparam int          ST_IBF         = 1;
  localparam int          ST_CMD         = 3;
  localparam int          ST_MOUSE       = 5;
  // Control fields
  localparam int          CT_IRQ_EN      = 0;
  localparam int          CT_MHOLD       = 1;
  // Keyboard flag register fields
  localparam int          KF_FLAG        = 0;
  localparam int          KF_OVR         = 1;
  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  // Host port select
  localparam logic        HOST_DATA_PORT = 1'b0;
  // Timing
  localparam int          CLK_HZ         = 250_000_000;
  localparam int          TICK_HZ        = 1_000_000;
  localparam int          TICK_DIV       = CLK_HZ / TICK_HZ;
  localparam int          RST_PULSE_US   = 6;
  localparam int          FIFO_DEPTH     = 32;

  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic [EC_AW-1:0]     addr;
    logic [DW-1:0]        wdata;
  } kbcof_ec_req_t;

  typedef struct packed {
    logic                 is_cmd;
    logic [DW-1:0]        data;
  } kbcof_in_word_t;

  typedef enum logic [0:0] {
    RST_IDLE  = 1'b0,
    RST_PULSE = 1'b1
  } kbcof_rst_state_t;
endpackage
`default_nettype wire

//--- logic/kbcof_top.sv
// Keyboard-controller output flags, input FIFO and reset pulse logic
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
module kbcof_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire  logic             core_clk,
  input  wire  logic             srst,
  input  wire  logic             in_valid,
  output logic                   in_ready,
  input  wire  logic [WIDTH-1:0] in_data,
  output logic                   out_valid,
  input  wire  logic             out_ready,
  output logic [WIDTH-1:0]       out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wp_r, wp_nxt;
  logic [PW-1:0]    rp_r, rp_nxt;
  logic [PW:0]      cnt_r, cnt_nxt;
  logic             rdy_r, rdy_nxt;
  logic             push;
  logic             pop;

  // Ready is registered so the host side sees a flop output
  assign in_ready  = rdy_r;
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
    rdy_nxt = (cnt_nxt != (PW+1)'(DEPTH));
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b1;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  // Storage needs no reset; only counted words are ever read
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule

//////////////////////////////////////////////////////////////////////////////
module kbcof_top (
  input  wire  logic                   core_clk,
  input  wire  logic                   srst,
  // EC register port
  input  wire  kbcof_pkg::kbcof_ec_req_t ec_req,
  output logic [kbcof_pkg::DW-1:0]     ec_rdata,
  // Host port
  input  wire  logic                   host_wr,
  input  wire  logic                   host_rd,
  input  wire  logic                   host_port_sel,
  input  wire  logic [kbcof_pkg::DW-1:0] host_wdata,
  output logic                         host_wr_ready,
  output logic [kbcof_pkg::DW-1:0]     host_rdata,
  // Sources toward the serial irq logic and the EC
  output logic                         keyboard_irq_source,
  output logic                         mouse_irq_source,
  output logic                         in_buffer_full_irq,
  output logic                         out_buffer_empty_irq,
  output logic                         keyboard_reset_out_n
);
  localparam int DW = kbcof_pkg::DW;
  localparam int IW = DW + 1;
  localparam int TW = $clog2(kbcof_pkg::TICK_DIV);
  localparam int PW = $clog2(kbcof_pkg::RST_PULSE_US + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(kbcof_pkg::TICK_DIV - 1);
  localparam logic [PW-1:0] PULSE_LEN = PW'(kbcof_pkg::RST_PULSE_US);

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic ec_wr_data, ec_wr_aux;
  logic ec_wr_status, ec_wr_ctrl;
  logic ec_wr_kbflag, ec_wr_rstctl;
  logic ec_rd_data, host_rd_data;

  assign ec_wr_data   = ec_req.wr && ec_req.addr == kbcof_pkg::OFS_DATA;
  assign ec_wr_aux    = ec_req.wr && ec_req.addr == kbcof_pkg::OFS_AUX;
  assign ec_wr_status = ec_req.wr && ec_req.addr == kbcof_pkg::OFS_STATUS;
  assign ec_wr_ctrl   = ec_req.wr && ec_req.addr == kbcof_pkg::OFS_CTRL;
  assign ec_wr_kbflag = ec_req.wr && ec_req.addr == kbcof_pkg::OFS_KBFLAG;
  assign ec_wr_rstctl = ec_req.wr && ec_req.addr == kbcof_pkg::OFS_RSTCTL;
  assign ec_rd_data   = ec_req.rd && ec_req.addr == kbcof_pkg::OFS_DATA;
  assign host_rd_data = host_rd && host_port_sel == kbcof_pkg::HOST_DATA_PORT;

  ////////////////////////////////////////////////////////////////////////////
  // Host-to-EC input path through the FIFO
  kbcof_pkg::kbcof_in_word_t fifo_in;
  kbcof_pkg::kbcof_in_word_t fifo_out;
  logic                      fifo_out_valid;
  logic                      fifo_pop;

  assign fifo_in.is_cmd = (host_port_sel != kbcof_pkg::HOST_DATA_PORT);
  assign fifo_in.data   = host_wdata;

  kbcof_fifo #(
    .WIDTH (IW),
    .DEPTH (kbcof_pkg::FIFO_DEPTH)
  ) u_in_fifo (
    .core_clk  (core_clk),
    .srst      (srst),
    .in_valid  (host_wr),
    .in_ready  (host_wr_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Flag state
  logic [DW-1:0] in_data_r, in_data_nxt;
  logic [DW-1:0] out_data_r, out_data_nxt;
  logic          ibf_r, ibf_nxt;
  logic          cmd_r, cmd_nxt;
  logic          obf_r, obf_nxt;
  logic          kb_hw_r, kb_hw_nxt;
  logic          kb_fw_r, kb_fw_nxt;
  logic          kb_ovr_r, kb_ovr_nxt;
  logic          ms_hw_r, ms_hw_nxt;
  logic          ms_fw_r, ms_fw_nxt;
  logic          irq_en_r, irq_en_nxt;
  logic          mhold_r, mhold_nxt;
  logic          kb_flag, kb_flag_nxt;
  logic          ms_flag, ms_flag_nxt;

  // Only drains when the EC has emptied the input register
  assign fifo_pop = fifo_out_valid && (!ibf_r || ec_rd_data);

  always_comb begin
    in_data_nxt  = in_data_r;
    cmd_nxt      = cmd_r;
    out_data_nxt = out_data_r;
    ibf_nxt      = ibf_r;
    obf_nxt      = obf_r;
    kb_hw_nxt    = kb_hw_r;
    ms_hw_nxt    = ms_hw_r;
    kb_fw_nxt    = kb_fw_r;
    kb_ovr_nxt   = kb_ovr_r;
    ms_fw_nxt    = ms_fw_r;
    irq_en_nxt   = irq_en_r;
    mhold_nxt    = mhold_r;
    if (ec_rd_data) begin
      ibf_nxt = 1'b0;
    end
    if (fifo_pop) begin
      in_data_nxt = fifo_out.data;
      cmd_nxt     = fifo_out.is_cmd;
      ibf_nxt     = 1'b1;
    end
    // Clears first so a same-cycle EC write wins
    if (host_rd_data) begin
      obf_nxt   = 1'b0;
      kb_hw_nxt = 1'b0;
      ms_hw_nxt = 1'b0;
    end
    if (ec_wr_data || ec_wr_aux) begin
      out_data_nxt = ec_req.wdata;
      obf_nxt      = 1'b1;
    end
    if (ec_wr_data) begin
      kb_hw_nxt = 1'b1;
    end
    if (ec_wr_aux) begin
      ms_hw_nxt = 1'b1;
    end
    if (ec_wr_status) begin
      ms_fw_nxt = ec_req.wdata[kbcof_pkg::ST_MOUSE];
    end
    if (ec_wr_kbflag) begin
      kb_fw_nxt  = ec_req.wdata[kbcof_pkg::KF_FLAG];
      kb_ovr_nxt = ec_req.wdata[kbcof_pkg::KF_OVR];
    end
    if (ec_wr_ctrl) begin
      irq_en_nxt = ec_req.wdata[kbcof_pkg::CT_IRQ_EN];
      mhold_nxt  = ec_req.wdata[kbcof_pkg::CT_MHOLD];
    end
  end

  // Present flags: firmware latch under override or hold
  assign kb_flag     = kb_ovr_r ? kb_fw_r : kb_hw_r;
  assign ms_flag     = mhold_r ? ms_fw_r : ms_hw_r;
  assign kb_flag_nxt = kb_ovr_nxt ? kb_fw_nxt : kb_hw_nxt;
  assign ms_flag_nxt = mhold_nxt ? ms_fw_nxt : ms_hw_nxt;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      in_data_r  <= kbcof_pkg::RESET_BYTE;
      out_data_r <= kbcof_pkg::RESET_BYTE;
      cmd_r      <= 1'b0;
      ibf_r      <= 1'b0;
      obf_r      <= 1'b0;
      kb_hw_r    <= 1'b0;
      kb_fw_r    <= 1'b0;
      kb_ovr_r   <= 1'b0;
      ms_hw_r    <= 1'b0;
      ms_fw_r    <= 1'b0;
      irq_en_r   <= 1'b0;
      mhold_r    <= 1'b0;
    end else begin
      in_data_r  <= in_data_nxt;
      out_data_r <= out_data_nxt;
      cmd_r      <= cmd_nxt;
      ibf_r      <= ibf_nxt;
      obf_r      <= obf_nxt;
      kb_hw_r    <= kb_hw_nxt;
      kb_fw_r    <= kb_fw_nxt;
      kb_ovr_r   <= kb_ovr_nxt;
      ms_hw_r    <= ms_hw_nxt;
      ms_fw_r    <= ms_fw_nxt;
      irq_en_r   <= irq_en_nxt;
      mhold_r    <= mhold_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset pulse timed by a 1 MHz enable
  kbcof_pkg::kbcof_rst_state_t rst_st_r, rst_st_nxt;
  logic [TW-1:0] div_r, div_nxt;
  logic [PW-1:0] pcnt_r, pcnt_nxt;
  logic          tick;

  assign tick = (div_r == TICK_LAST);

  always_comb begin
    div_nxt    = tick ? '0 : div_r + 1'b1;
    rst_st_nxt = rst_st_r;
    pcnt_nxt   = pcnt_r;
    case (rst_st_r)
      kbcof_pkg::RST_IDLE: begin
        if (ec_wr_rstctl && ec_req.wdata[0]) begin
          rst_st_nxt = kbcof_pkg::RST_PULSE;
          pcnt_nxt   = '0;
        end
      end
      kbcof_pkg::RST_PULSE: begin
        if (tick) begin
          pcnt_nxt = pcnt_r + 1'b1;
          if (pcnt_r == PULSE_LEN - 1'b1) begin
            rst_st_nxt = kbcof_pkg::RST_IDLE;
          end
        end
      end
      default: rst_st_nxt = kbcof_pkg::RST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rst_st_r <= kbcof_pkg::RST_IDLE;
      div_r    <= '0;
      pcnt_r   <= '0;
    end else begin
      rst_st_r <= rst_st_nxt;
      div_r    <= div_nxt;
      pcnt_r   <= pcnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  logic [DW-1:0] ec_rdata_nxt, host_rdata_nxt;
  logic [DW-1:0] status;

  always_comb begin
    status = '0;
    status[kbcof_pkg::ST_OBF]   = obf_r;
    status[kbcof_pkg::ST_IBF]   = ibf_r;
    status[kbcof_pkg::ST_CMD]   = cmd_r;
    status[kbcof_pkg::ST_MOUSE] = ms_flag;
    ec_rdata_nxt = '0;
    if (ec_req.rd) begin
      case (ec_req.addr)
        kbcof_pkg::OFS_DATA:   ec_rdata_nxt = in_data_r;
        kbcof_pkg::OFS_STATUS: ec_rdata_nxt = status;
        kbcof_pkg::OFS_CTRL: begin
          ec_rdata_nxt[kbcof_pkg::CT_IRQ_EN] = irq_en_r;
          ec_rdata_nxt[kbcof_pkg::CT_MHOLD]  = mhold_r;
        end
        kbcof_pkg::OFS_KBFLAG: begin
          ec_rdata_nxt[kbcof_pkg::KF_FLAG] = kb_flag;
          ec_rdata_nxt[kbcof_pkg::KF_OVR]  = kb_ovr_r;
        end
        default: ec_rdata_nxt = '0;
      endcase
    end
    host_rdata_nxt = '0;
    if (host_rd) begin
      host_rdata_nxt = host_rd_data ? out_data_r : status;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ec_rdata             <= '0;
      host_rdata           <= '0;
      keyboard_irq_source  <= 1'b0;
      mouse_irq_source     <= 1'b0;
      in_buffer_full_irq   <= 1'b0;
      out_buffer_empty_irq <= 1'b0;
      keyboard_reset_out_n <= 1'b1;
    end else begin
      ec_rdata             <= ec_rdata_nxt;
      host_rdata           <= host_rdata_nxt;
      keyboard_irq_source  <= irq_en_nxt && kb_flag_nxt;
      mouse_irq_source     <= irq_en_nxt && ms_flag_nxt;
      in_buffer_full_irq   <= ibf_nxt && !ibf_r;
      out_buffer_empty_irq <= obf_r && !obf_nxt;
      keyboard_reset_out_n <= (rst_st_nxt != kbcof_pkg::RST_PULSE);
    end
  end
endmodule
`default_nettype wire

//--- verification/kbcof_asserts.sv
// Concurrent checks on the keyboard controller flag and event ports
`default_nettype none
module kbcof_asserts (
  input wire logic                     core_clk,
  input wire logic                     srst,
  input wire kbcof_pkg::kbcof_ec_req_t ec_req,
  input wire logic                     host_rd,
  input wire logic                     host_port_sel,
  input wire logic                     keyboard_irq_source,
  input wire logic                     mouse_irq_source,
  input wire logic                     in_buffer_full_irq,
  input wire logic                     out_buffer_empty_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  // Shadow of override, mouse hold and irq enable, seen from EC writes
  logic [2:0] cfg_r;
  logic [2:0] cfg_nxt;
  logic       en;
  logic       hold;
  logic       ovr;
  logic       hrd;
  logic       drd;
  logic       dw;
  logic       aw;
  assign {ovr, hold, en} = cfg_r;
  assign hrd = host_rd && host_port_sel == kbcof_pkg::HOST_DATA_PORT;
  // Same-cycle EC write wins over the host read
  assign drd = hrd && !ec_req.wr;
  assign dw  = ec_req.wr && ec_req.addr == kbcof_pkg::OFS_DATA;
  assign aw  = ec_req.wr && ec_req.addr == kbcof_pkg::OFS_AUX;
  always_comb begin
    cfg_nxt = cfg_r;
    if (ec_req.wr && ec_req.addr == kbcof_pkg::OFS_CTRL) begin
      cfg_nxt[1] = ec_req.wdata[kbcof_pkg::CT_MHOLD];
      cfg_nxt[0] = ec_req.wdata[kbcof_pkg::CT_IRQ_EN];
    end
    if (ec_req.wr && ec_req.addr == kbcof_pkg::OFS_KBFLAG) begin
      cfg_nxt[2] = ec_req.wdata[kbcof_pkg::KF_OVR];
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_r <= 3'h0;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////
  kb_set_a: assert property (dw && en && !ovr |=> keyboard_irq_source)
    else $error("keyboard irq not raised by data write");
  mouse_set_a: assert property (aw && en && !hold |=> mouse_irq_source)
    else $error("mouse irq not raised by aux write");
  kb_clear_a: assert property (drd && !ovr |=> !keyboard_irq_source)
    else $error("keyboard irq not cleared by host read");
  mouse_clear_a: assert property (drd && !hold |=> !mouse_irq_source)
    else $error("mouse irq not cleared by host read");
  kb_gate_a: assert property (
    !en && !$past(en) |-> !keyboard_irq_source)
    else $error("keyboard irq high while disabled");
  mouse_gate_a: assert property (
    !en && !$past(en) |-> !mouse_irq_source)
    else $error("mouse irq high while disabled");
  obe_cause_a: assert property (out_buffer_empty_irq |-> $past(hrd))
    else $error("empty event without host data read");
  obe_once_a: assert property (
    out_buffer_empty_irq |=> !out_buffer_empty_irq)
    else $error("empty event longer than one cycle");
  ibf_once_a: assert property (
    in_buffer_full_irq |=> !in_buffer_full_irq)
    else $error("input full event longer than one cycle");
endmodule
`default_nettype wire

//--- verification/kbcof_host_model.sv
// Host software model on the data and command ports
`default_nettype none
module kbcof_host_model (
  input  wire logic       core_clk,
  output logic            host_wr,
  output logic            host_rd,
  output logic            host_port_sel,
  output logic [7:0]      host_wdata,
  input  wire logic       host_wr_ready,
  input  wire logic [7:0] host_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // Irq line routing is left to host software
  initial begin
    {host_wr, host_rd, host_port_sel} = 3'h0;
    host_wdata = 8'hFF;
  end
  task automatic write_byte(input logic s, input logic [7:0] v);
    @(posedge core_clk);
    #1;
    {host_wr, host_port_sel, host_wdata} = {1'b1, s, v};
    while (host_wr_ready !== 1'b1) begin
      #4;
    end
    @(posedge core_clk);
    #1;
    host_wr = 1'b0;
    // Released bus never repeats the byte
    host_wdata = ~v;
  endtask
  task automatic read_byte(input logic s, output logic [7:0] v);
    @(posedge core_clk);
    #1;
    {host_rd, host_port_sel} = {1'b1, s};
    @(posedge core_clk);
    #1;
    host_rd = 1'b0;
    v = host_rdata;
  endtask
endmodule
`default_nettype wire

//--- verification/tb_kbcof_top.sv
// Self-checking bench for the keyboard controller flag block
`default_nettype none
module tb_kbcof_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [4:0] A_DAT = kbcof_pkg::OFS_DATA;
  localparam logic [4:0] A_ST  = kbcof_pkg::OFS_STATUS;
  localparam logic [4:0] A_CT  = kbcof_pkg::OFS_CTRL;
  localparam logic [4:0] A_AUX = kbcof_pkg::OFS_AUX;
  localparam logic [4:0] A_KF  = kbcof_pkg::OFS_KBFLAG;
  localparam logic [4:0] A_RC  = kbcof_pkg::OFS_RSTCTL;
  logic                     core_clk, srst, host_wr, host_rd, host_port_sel;
  logic                     host_wr_ready, keyboard_irq_source;
  logic                     mouse_irq_source;
  logic                     in_buffer_full_irq, out_buffer_empty_irq;
  logic                     keyboard_reset_out_n;
  logic [1:0]               irqs;
  logic [7:0]               ec_rdata, host_wdata, host_rdata, d;
  kbcof_pkg::kbcof_ec_req_t ec_req;
  int                       error_cnt, n_tests, ibf_cnt, obe_cnt, n, t;
  assign irqs = {mouse_irq_source, keyboard_irq_source};
  kbcof_top kbcof_top_inst (
    .core_clk(core_clk), .srst(srst), .ec_req(ec_req), .ec_rdata(ec_rdata),
    .host_wr(host_wr), .host_rd(host_rd), .host_port_sel(host_port_sel),
    .host_wdata(host_wdata), .host_wr_ready(host_wr_ready),
    .host_rdata(host_rdata), .keyboard_irq_source(keyboard_irq_source),
    .mouse_irq_source(mouse_irq_source),
    .in_buffer_full_irq(in_buffer_full_irq),
    .out_buffer_empty_irq(out_buffer_empty_irq),
    .keyboard_reset_out_n(keyboard_reset_out_n));
  kbcof_host_model kbcof_host_model_inst (
    .core_clk(core_clk), .host_wr(host_wr), .host_rd(host_rd),
    .host_port_sel(host_port_sel), .host_wdata(host_wdata),
    .host_wr_ready(host_wr_ready), .host_rdata(host_rdata));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Single-cycle events are counted, not sampled by the sequence
  initial begin
    {ibf_cnt, obe_cnt, error_cnt, n_tests} = '0;
    forever begin
      @(posedge core_clk);
      if (in_buffer_full_irq === 1'b1) ibf_cnt++;
      if (out_buffer_empty_irq === 1'b1) obe_cnt++;
    end
  end
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ec(input logic w, input logic [4:0] a, input logic [7:0] v);
    @(posedge core_clk);
    #1;
    ec_req = '{wr: w, rd: !w, addr: a, wdata: v};
    @(posedge core_clk);
    #1;
    ec_req = '0;
    d = ec_rdata;
  endtask
  task automatic hr(input logic s);
    kbcof_host_model_inst.read_byte(s, d);
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge core_clk);
    error_cnt++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    ec_req = '0;
    repeat (6) @(posedge core_clk);
    #1;
    srst = 1'b0;
    chk("rst_out", 8'h01, keyboard_reset_out_n);
    chk("irqs", 8'h00, irqs);
    ec(1'b0, A_KF, 8'h00);
    chk("kbflag", 8'h00, d);
    ec(1'b0, A_ST, 8'h00);
    chk("status", 8'h00, d);
    ec(1'b1, A_CT, 8'h01);
    ec(1'b1, A_DAT, 8'h5A);
    chk("irqs", 8'h01, irqs);
    ec(1'b0, A_ST, 8'h00);
    chk("obf", 8'h01, d[0]);
    ec(1'b0, A_KF, 8'h00);
    chk("kbflag", 8'h01, d[0]);
    hr(1'b0);
    chk("hdata", 8'h5A, d);
    chk("irqs", 8'h00, irqs);
    ec(1'b0, A_ST, 8'h00);
    chk("obf", 8'h00, d[0]);
    chk("obe", 8'h01, obe_cnt[7:0]);
    ec(1'b1, A_AUX, 8'hA5);
    chk("irqs", 8'h02, irqs);
    ec(1'b0, A_ST, 8'h00);
    chk("st_aux", 8'h21, d & 8'h21);
    hr(1'b0);
    chk("hdata", 8'hA5, d);
    chk("irqs", 8'h00, irqs);
    ec(1'b1, A_CT, 8'h00);
    ec(1'b1, A_DAT, 8'h33);
    ec(1'b1, A_AUX, 8'h44);
    chk("gated", 8'h00, irqs);
    ec(1'b1, A_CT, 8'h01);
    chk("ungated", 8'h03, irqs);
    hr(1'b0);
    chk("hdata", 8'h44, d);
    chk("irqs", 8'h00, irqs);
    ec(1'b1, A_KF, 8'h03);
    chk("ovr_set", 8'h01, irqs);
    hr(1'b0);
    chk("ovr_hold", 8'h01, irqs);
    ec(1'b0, A_KF, 8'h00);
    chk("kbflag", 8'h03, d & 8'h03);
    ec(1'b1, A_KF, 8'h02);
    ec(1'b1, A_DAT, 8'h66);
    chk("ovr_mask", 8'h00, irqs);
    ec(1'b0, A_KF, 8'h00);
    chk("kbflag", 8'h02, d & 8'h03);
    ec(1'b1, A_KF, 8'h00);
    chk("hw_flag", 8'h01, irqs);
    hr(1'b0);
    ec(1'b1, A_CT, 8'h03);
    ec(1'b1, A_ST, 8'h20);
    chk("fw_mouse", 8'h02, irqs);
    hr(1'b0);
    chk("fw_hold", 8'h02, irqs);
    ec(1'b1, A_ST, 8'h00);
    ec(1'b1, A_AUX, 8'h11);
    chk("fw_mask", 8'h00, irqs);
    ec(1'b1, A_CT, 8'h01);
    chk("hw_mouse", 8'h02, irqs);
    hr(1'b1);
    chk("hstat", 8'h01, d[0]);
    hr(1'b0);
    // Fill the input path until refused, then drain in order
    n = 0;
    while (host_wr_ready === 1'b1 && n < 40) begin
      kbcof_host_model_inst.write_byte(1'b0, n[7:0]);
      n++;
    end
    chk("ibf", 8'h01, ibf_cnt[7:0]);
    chk("depth", 8'h01, n >= 32 && n < 40);
    for (t = 0; t < n; t++) begin
      ec(1'b0, A_DAT, 8'h00);
      chk("fifo", t[7:0], d);
    end
    ec(1'b0, A_ST, 8'h00);
    chk("ibf_clr", 8'h00, d[1]);
    // Command port byte marks the status and raises a second input event
    kbcof_host_model_inst.write_byte(1'b1, 8'hC3);
    ec(1'b0, A_ST, 8'h00);
    chk("st_cmd", 8'h0A, d & 8'h0A);
    chk("ibf_ev", 8'h02, ibf_cnt[7:0]);
    ec(1'b0, A_DAT, 8'h00);
    chk("cmd_byte", 8'hC3, d);
    ec(1'b1, 5'h18, 8'hFF);
    ec(1'b0, 5'h18, 8'h00);
    chk("unmapped", 8'h00, d);
    // Reset in mid-run with both flags and the enable set
    ec(1'b1, A_DAT, 8'h77);
    ec(1'b1, A_AUX, 8'h78);
    chk("pre_rst", 8'h03, irqs);
    @(posedge core_clk);
    #1;
    srst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    srst = 1'b0;
    chk("rst_irqs", 8'h00, irqs);
    ec(1'b0, A_ST, 8'h00);
    chk("rst_st", 8'h00, d);
    ec(1'b0, A_CT, 8'h00);
    chk("rst_ct", 8'h00, d);
    ec(1'b1, A_RC, 8'h01);
    for (t = 0; t < 600 && keyboard_reset_out_n !== 1'b0; t++) #4;
    for (n = 0; n < 2000 && keyboard_reset_out_n === 1'b0; n++) #4;
    chk("rst_len", 8'h01, n >= 1200 && n <= 1550);
    print_verdict();
  end
endmodule
bind kbcof_top kbcof_asserts kbcof_asserts_inst (
  .core_clk(core_clk), .srst(srst), .ec_req(ec_req), .host_rd(host_rd),
  .host_port_sel(host_port_sel), .keyboard_irq_source(keyboard_irq_source),
  .mouse_irq_source(mouse_irq_source),
  .in_buffer_full_irq(in_buffer_full_irq),
  .out_buffer_empty_irq(out_buffer_empty_irq));
`default_nettype wire
